// *** hw/nvsc_pkg.sv ***
// Package with timing, strobe bundle and state codes for the nonvolatile store/recall controller.
package nvsc_pkg;

  // ************************************************************
  // Clock and timing figures
  // ************************************************************

  // Period of mclk_i in nanoseconds (20 MHz).
  localparam int unsigned NVSC_CLK_PERIOD_NS = 50;

  // Least setup of the steady strobes before the chip-enable edge, in ns.
  localparam int unsigned NVSC_T_SETUP_NS = 5;
  // Least time the initiating strobe state must be held, in ns.
  localparam int unsigned NVSC_T_INIT_NS = 25;
  // Longest recall cycle time, in microseconds.
  localparam int unsigned NVSC_T_RECALL_US = 20;
  // Longest store cycle time, in milliseconds.
  localparam int unsigned NVSC_T_STORE_MS = 10;

  // Least times round up to whole cycles, never below one.
  localparam int unsigned NVSC_SETUP_CYC =
    (NVSC_T_SETUP_NS + NVSC_CLK_PERIOD_NS - 1) / NVSC_CLK_PERIOD_NS;
  localparam int unsigned NVSC_INIT_CYC =
    (NVSC_T_INIT_NS + NVSC_CLK_PERIOD_NS - 1) / NVSC_CLK_PERIOD_NS;
  // The host must wait out the whole worst case, so completion waits round up too.
  localparam int unsigned NVSC_RECALL_CYC =
    (NVSC_T_RECALL_US * 1000 + NVSC_CLK_PERIOD_NS - 1) / NVSC_CLK_PERIOD_NS;
  localparam int unsigned NVSC_STORE_CYC =
    (NVSC_T_STORE_MS * 1000000 + NVSC_CLK_PERIOD_NS - 1) / NVSC_CLK_PERIOD_NS;

  // Width of the shared delay counter; holds the store wait.
  localparam int unsigned NVSC_CNT_W = 18;

  // ************************************************************
  // Strobe bundle driven onto the device pins
  // ************************************************************

  // All four strobes are active low.
  typedef struct packed {
    logic chip_enable_n;
    logic output_enable_n;
    logic write_enable_n;
    logic nonvolatile_request_n;
  } nvsc_strobes_t;

  // Every strobe deasserted: SRAM deselected, no nonvolatile request.
  localparam nvsc_strobes_t NVSC_STROBES_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1};
  // Recall pattern before the chip-enable edge: output enable and request low.
  localparam nvsc_strobes_t NVSC_STROBES_RECALL = '{1'b1, 1'b0, 1'b1, 1'b0};
  // Store pattern before the chip-enable edge: write enable and request low.
  localparam nvsc_strobes_t NVSC_STROBES_STORE = '{1'b1, 1'b1, 1'b0, 1'b0};

  // ************************************************************
  // Sequencer states
  // ************************************************************

  typedef enum logic [3:0] {
    NVSC_IDLE  = 4'h1,
    NVSC_SETUP = 4'h2,
    NVSC_INIT  = 4'h4,
    NVSC_WAIT  = 4'h8
  } nvsc_state_t;

endpackage

// *** hw/nvsc_delay.sv ***
// Loadable down-counter that times each phase of the strobe sequence.
`timescale 1ns/100ps

module nvsc_delay
  import nvsc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic load_i,
  input wire logic [NVSC_CNT_W-1:0] value_i,
  output logic zero_o
);

  // Remaining cycles of the current phase.
  logic [NVSC_CNT_W-1:0] count_q;

  // ************************************************************
  // Count
  // ************************************************************

  // A load wins over the decrement; the counter rests at zero.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count_q <= '0;
    end else if (ce_i) begin
      if (load_i) begin
        count_q <= value_i;
      end else if (count_q != '0) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

  // Zero flags the last cycle of a phase.
  assign zero_o = (count_q == '0);

endmodule

// *** hw/nvsc_ctrl.sv ***
// Host sequencer that starts store and recall cycles on a nonvolatile SRAM by its strobes.
`timescale 1ns/100ps

// Operation
// - End recall initiation by raising a strobe
// - Hold recall initiating state at least 25 ns
// - End store initiation by raising a strobe
// - Keep other strobes static during chip-enable store
module nvsc_ctrl
  import nvsc_pkg::*;
#(
  // Store wait in cycles; shorten it in simulation.
  parameter int unsigned STORE_WAIT_CYC = NVSC_STORE_CYC
)
(
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic store_req_i,
  input wire logic recall_req_i,
  input wire logic supply_good_i,
  input wire logic store_feature_strap_i,
  output nvsc_strobes_t strobes_o,
  output logic busy_o,
  output logic done_o,
  output logic refused_o
);

  // ************************************************************
  // Declarations
  // ************************************************************

  // Sequencer state and its next value.
  nvsc_state_t state_q;
  nvsc_state_t state_d;
  // Strobes as registered onto the pins, and their next value.
  nvsc_strobes_t strobes_q;
  nvsc_strobes_t strobes_d;
  // High while the running operation is a store.
  logic is_store_q;
  logic is_store_d;
  // Status flops behind busy_o, done_o and refused_o.
  logic busy_q;
  logic done_q;
  logic refused_q;
  // Synchronisers for the two board-level inputs.
  logic supply_q1;
  logic supply_q2;
  logic strap_q1;
  logic strap_q2;
  // Phase counter control.
  logic cnt_load;
  logic [NVSC_CNT_W-1:0] cnt_value;
  logic cnt_zero;
  // Request decode in idle.
  logic want_store;
  logic want_recall;
  logic refuse;

  // ************************************************************
  // Input synchronisers
  // ************************************************************

  // Supply monitor and strap come from pins, so each passes two flops.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      supply_q1 <= 1'b0;
      supply_q2 <= 1'b0;
      strap_q1 <= 1'b0;
      strap_q2 <= 1'b0;
    end else if (ce_i) begin
      supply_q1 <= supply_good_i;
      supply_q2 <= supply_q1;
      strap_q1 <= store_feature_strap_i;
      strap_q2 <= strap_q1;
    end
  end

  // ************************************************************
  // Request decode
  // ************************************************************

  // Store has priority when both are asked at once. Without the strap the
  // device ignores strobe operations, so asking would only waste a cycle.
  assign want_store = store_req_i && strap_q2 && supply_q2;
  assign want_recall = recall_req_i && strap_q2 && !store_req_i;
  assign refuse = (store_req_i || recall_req_i) && !want_store && !want_recall;

  // ************************************************************
  // Next-state logic
  // ************************************************************

  // Each operation: steady strobes set with chip enable high, then the chip
  // enable falls as the initiating edge, then rises to end initiation, then
  // the worst-case cycle time is waited out with the pattern left alone.
  always_comb begin
    state_d = state_q;
    strobes_d = strobes_q;
    is_store_d = is_store_q;
    cnt_load = 1'b0;
    cnt_value = '0;
    unique case (state_q)
      NVSC_IDLE: begin
        // Strobes rest deasserted, so the next start is a true transition.
        if (want_store) begin
          strobes_d = NVSC_STROBES_STORE;
          is_store_d = 1'b1;
          state_d = NVSC_SETUP;
          cnt_load = 1'b1;
          cnt_value = NVSC_CNT_W'(NVSC_SETUP_CYC - 1);
        end else if (want_recall) begin
          strobes_d = NVSC_STROBES_RECALL;
          is_store_d = 1'b0;
          state_d = NVSC_SETUP;
          cnt_load = 1'b1;
          cnt_value = NVSC_CNT_W'(NVSC_SETUP_CYC - 1);
        end
      end
      NVSC_SETUP: begin
        // Chip enable arrives last and starts the operation.
        if (cnt_zero) begin
          strobes_d.chip_enable_n = 1'b0;
          state_d = NVSC_INIT;
          cnt_load = 1'b1;
          cnt_value = NVSC_CNT_W'(NVSC_INIT_CYC - 1);
        end
      end
      NVSC_INIT: begin
        // Raising chip enable alone ends initiation; the rest stay put.
        if (cnt_zero) begin
          strobes_d.chip_enable_n = 1'b1;
          state_d = NVSC_WAIT;
          cnt_load = 1'b1;
          if (is_store_q) begin
            cnt_value = NVSC_CNT_W'(STORE_WAIT_CYC - 1);
          end else begin
            cnt_value = NVSC_CNT_W'(NVSC_RECALL_CYC - 1);
          end
        end
      end
      NVSC_WAIT: begin
        // The device ignores the pins now, so nothing moves until the end.
        if (cnt_zero) begin
          strobes_d = NVSC_STROBES_IDLE;
          state_d = NVSC_IDLE;
        end
      end
      default: begin
        // An illegal code falls back to a safe idle.
        strobes_d = NVSC_STROBES_IDLE;
        state_d = NVSC_IDLE;
      end
    endcase
  end

  // ************************************************************
  // Phase timer
  // ************************************************************

  // One counter serves every phase, as only one phase runs at a time.
  nvsc_delay u_delay (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .load_i(cnt_load),
    .value_i(cnt_value),
    .zero_o(cnt_zero)
  );

  // ************************************************************
  // Sequencer registers
  // ************************************************************

  // State, strobes and operation kind advance together.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= NVSC_IDLE;
      strobes_q <= NVSC_STROBES_IDLE;
      is_store_q <= 1'b0;
    end else if (ce_i) begin
      state_q <= state_d;
      strobes_q <= strobes_d;
      is_store_q <= is_store_d;
    end
  end

  // ************************************************************
  // Status outputs
  // ************************************************************

  // Busy follows the next state; done is a one-cycle pulse, refused is high in the cycle after each idle cycle that holds a refused request.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      refused_q <= 1'b0;
    end else if (ce_i) begin
      busy_q <= (state_d != NVSC_IDLE);
      done_q <= (state_q == NVSC_WAIT) && cnt_zero;
      refused_q <= (state_q == NVSC_IDLE) && refuse;
    end
  end

  assign strobes_o = strobes_q;
  assign busy_o = busy_q;
  assign done_o = done_q;
  assign refused_o = refused_q;

  // ************************************************************
  // Assertions
  // ************************************************************

  property p_recall_pattern;
    @(posedge mclk_i) disable iff (!resetn_i)
    $fell(strobes_q.chip_enable_n) && strobes_q.write_enable_n |->
      !strobes_q.output_enable_n && !strobes_q.nonvolatile_request_n;
  endproperty
  a_recall_pattern: assert property (p_recall_pattern) else $error("bad recall pattern");

  property p_store_pattern;
    @(posedge mclk_i) disable iff (!resetn_i)
    $fell(strobes_q.chip_enable_n) && !strobes_q.write_enable_n |->
      strobes_q.output_enable_n && !strobes_q.nonvolatile_request_n;
  endproperty
  a_store_pattern: assert property (p_store_pattern) else $error("bad store pattern");

  property p_init_hold;
    @(posedge mclk_i) disable iff (!resetn_i || !ce_i)
    $fell(strobes_q.chip_enable_n) |=> $rose(strobes_q.chip_enable_n);
  endproperty
  a_init_hold: assert property (p_init_hold) else $error("initiation hold wrong");

  property p_static_strobes;
    @(posedge mclk_i) disable iff (!resetn_i)
    !strobes_q.chip_enable_n |-> $stable(strobes_q.write_enable_n) &&
      $stable(strobes_q.output_enable_n) && $stable(strobes_q.nonvolatile_request_n);
  endproperty
  a_static_strobes: assert property (p_static_strobes) else $error("strobe moved in init");

  property p_end_by_enable;
    @(posedge mclk_i) disable iff (!resetn_i)
    $rose(strobes_q.chip_enable_n) |-> !strobes_q.nonvolatile_request_n && busy_o;
  endproperty
  a_end_by_enable: assert property (p_end_by_enable) else $error("initiation not ended");

  // Cycles spent in the recall wait, for the check below. A counter keeps the
  // property free of a long delay, and it freezes with the clock enable.
  logic [NVSC_CNT_W-1:0] recall_age_q;
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      recall_age_q <= '0;
    end else if (ce_i) begin
      recall_age_q <= (state_q == NVSC_WAIT && !is_store_q) ? recall_age_q + 1'b1 : '0;
    end
  end

  property p_recall_time;
    @(posedge mclk_i) disable iff (!resetn_i)
    !is_store_q && (state_q == NVSC_WAIT || done_o) |->
      (done_o ? recall_age_q == NVSC_CNT_W'(NVSC_RECALL_CYC) :
        recall_age_q < NVSC_CNT_W'(NVSC_RECALL_CYC));
  endproperty
  a_recall_time: assert property (p_recall_time) else $error("recall wait wrong");

  property p_supply_refuse;
    @(posedge mclk_i) disable iff (!resetn_i)
    ce_i && state_q == NVSC_IDLE && store_req_i && !supply_q2 && !recall_req_i |=>
      refused_o && !busy_o;
  endproperty
  a_supply_refuse: assert property (p_supply_refuse) else $error("store not refused");

  property p_strap_refuse;
    @(posedge mclk_i) disable iff (!resetn_i)
    ce_i && state_q == NVSC_IDLE && (store_req_i || recall_req_i) && !strap_q2 |=>
      refused_o && strobes_q == NVSC_STROBES_IDLE;
  endproperty
  a_strap_refuse: assert property (p_strap_refuse) else $error("strap not honoured");

  property p_idle_after;
    @(posedge mclk_i) disable iff (!resetn_i)
    done_o |-> strobes_q == NVSC_STROBES_IDLE && !busy_o;
  endproperty
  a_idle_after: assert property (p_idle_after) else $error("strobes not released");

endmodule

// *** dv/nvsc_nvsram_model.sv ***
// Behavioural model of the nonvolatile SRAM die's store/recall control.
`timescale 1ns/100ps

module nvsc_nvsram_model
  import nvsc_pkg::*;
#(
  // Recall and store run times in ns; both sit inside the host's waits.
  parameter int unsigned RECALL_NS = 15000,
  parameter int unsigned STORE_NS = 800
)
(
  input wire nvsc_strobes_t strobes_i,
  input wire logic supply_good_i,
  input wire logic strap_i,
  output logic busy_o,
  output logic [1:0] last_op_o,
  output logic [7:0] starts_o,
  output logic [7:0] viol_o
);
  // ************************************************************
  // Strobe decode
  // ************************************************************
  logic rec_w; // Recall state on the strobes.
  logic sto_w; // Store state on the strobes.
  realtime t0; // Time the current operation was triggered.

  assign rec_w = !strobes_i.chip_enable_n && !strobes_i.output_enable_n &&
    strobes_i.write_enable_n && !strobes_i.nonvolatile_request_n;
  assign sto_w = !strobes_i.chip_enable_n && strobes_i.output_enable_n &&
    !strobes_i.write_enable_n && !strobes_i.nonvolatile_request_n;

  initial begin
    busy_o = 1'b0;
    last_op_o = 2'h0;
    starts_o = 8'h00;
    viol_o = 8'h00;
    t0 = 0.0;
  end

  // Runs one operation; the trigger process is stalled meanwhile, so strobes are ignored.
  task automatic start(input logic [1:0] kind, input int unsigned dur);
    busy_o = 1'b1;
    last_op_o = kind;
    starts_o = starts_o + 8'h01;
    t0 = $realtime;
    #(dur);
    busy_o = 1'b0;
  endtask

  // ************************************************************
  // Trigger, only on a change of the decoded state
  // ************************************************************
  // A state that merely persists past the end of an operation starts nothing.
  always @(rec_w or sto_w) begin
    if (!busy_o && strap_i === 1'b1) begin
      if (sto_w && supply_good_i === 1'b1) begin
        start(2'h1, STORE_NS);
      end else if (rec_w) begin
        start(2'h2, RECALL_NS);
      end
    end
  end

  // The host must hold the initiating state 25 ns before ending it.
  always @(rec_w or sto_w) begin
    if (busy_o && !rec_w && !sto_w && ($realtime - t0) < 25.0) begin
      viol_o = viol_o + 8'h01;
    end
  end
endmodule

// *** dv/nvsram_store_recall_control_bench.sv ***
// Self-checking testbench for the store/recall sequencer against the die model.
`timescale 1ns/100ps

module nvsram_store_recall_control_bench;
  import nvsc_pkg::*;

  // ************************************************************
  // Signals
  // ************************************************************
  logic mclk_i;
  logic resetn_i;
  logic ce_i;
  logic store_req;
  logic recall_req;
  logic supply_good;
  logic strap;
  nvsc_strobes_t strobes;
  logic busy;
  logic done;
  logic refused;
  logic m_busy;
  logic [1:0] m_last;
  logic [7:0] m_starts;
  logic [7:0] m_viol;
  logic [1:0] notes[$]; // Expected result codes: 1 store, 2 recall, 3 refused.
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  int exp_starts = 0;
  integer seed = 32'he92037a1;
  logic [31:0] r;

  // Short store wait keeps the run brief; the model's store fits inside it.
  nvsc_ctrl #(.STORE_WAIT_CYC(20)) u_nvsc_ctrl (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .ce_i(ce_i), .store_req_i(store_req),
    .recall_req_i(recall_req), .supply_good_i(supply_good),
    .store_feature_strap_i(strap), .strobes_o(strobes), .busy_o(busy),
    .done_o(done), .refused_o(refused));

  nvsc_nvsram_model u_nvsc_nvsram_model (
    .strobes_i(strobes), .supply_good_i(supply_good), .strap_i(strap),
    .busy_o(m_busy), .last_op_o(m_last), .starts_o(m_starts), .viol_o(m_viol));

  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results();
    if (mismatches == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Waits, bounded, until only n notes are left; a stuck result is flagged.
  task automatic wait_left(input int n);
    for (int i = 0; i < 1000 && notes.size() > n; i++) @(posedge mclk_i);
    if (notes.size() > n) begin
      check(8'(notes.size()), 8'(n));
      notes.delete();
    end
  endtask

  // One-cycle request pulse with its expected outcome noted first.
  task automatic op(input logic s, input logic rc, input logic [1:0] code);
    notes.push_back(code);
    if (code != 2'h3) exp_starts++;
    @(posedge mclk_i);
    store_req <= s;
    recall_req <= rc;
    @(posedge mclk_i);
    store_req <= 1'b0;
    recall_req <= 1'b0;
    // A taken request shows busy one cycle later; a refused one never does.
    @(posedge mclk_i);
    check({7'h00, busy}, {7'h00, code != 2'h3});
    wait_left(0);
  endtask

  // ************************************************************
  // Result watcher and hang guard
  // ************************************************************
  // A finished operation must also be finished inside the die.
  always @(posedge mclk_i) begin
    if (resetn_i === 1'b1 && (done === 1'b1 || refused === 1'b1)) begin
      if (notes.size() == 0) check(8'hff, 8'h00);
      else check({4'h0, busy, m_busy, refused ? 2'h3 : m_last}, {6'h00, notes.pop_front()});
    end
  end

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      results();
    end
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    resetn_i = 1'b0;
    ce_i = 1'b1;
    store_req = 1'b0;
    recall_req = 1'b0;
    supply_good = 1'b1;
    strap = 1'b1;
    repeat (5) @(posedge mclk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    check({4'h0, strobes}, {4'h0, NVSC_STROBES_IDLE});
    op(1'b0, 1'b1, 2'h2);
    op(1'b1, 1'b0, 2'h1);
    op(1'b1, 1'b1, 2'h1);
    // A held request gives two separate operations, each on a fresh transition.
    notes.push_back(2'h2);
    notes.push_back(2'h2);
    exp_starts += 2;
    @(posedge mclk_i);
    recall_req <= 1'b1;
    wait_left(1);
    @(posedge mclk_i);
    recall_req <= 1'b0;
    wait_left(0);
    // Low supply blocks a store but not a recall; sync takes two cycles.
    supply_good <= 1'b0;
    repeat (4) @(posedge mclk_i);
    op(1'b1, 1'b0, 2'h3);
    op(1'b1, 1'b1, 2'h3);
    op(1'b0, 1'b1, 2'h2);
    supply_good <= 1'b1;
    strap <= 1'b0;
    repeat (4) @(posedge mclk_i);
    op(1'b1, 1'b0, 2'h3);
    op(1'b0, 1'b1, 2'h3);
    strap <= 1'b1;
    repeat (4) @(posedge mclk_i);
    // Random mix with idle gaps, some of them with the clock enable dropped.
    for (int k = 0; k < 10; k++) begin
      r = $random(seed);
      ce_i <= r[4];
      repeat (r[3:0] + 5'h01) @(posedge mclk_i);
      ce_i <= 1'b1;
      if (r[6:5] == 2'h1) op(1'b0, 1'b1, 2'h2);
      else op(r[6:5] != 2'h3, r[6:5] == 2'h3, r[6:5] == 2'h3 ? 2'h2 : 2'h1);
    end
    repeat (4) @(posedge mclk_i);
    check(m_starts, 8'(exp_starts));
    check(m_viol, 8'h00);
    results();
  end
endmodule
